// file: logic/cbfle_cfg.svh
`ifndef CBFLE_CFG_SVH
`define CBFLE_CFG_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CBFLE_ADDR_INSTR    8'h00
`define CBFLE_ADDR_FLAGS    8'h04
`define CBFLE_ADDR_PC       8'h08
`define CBFLE_ADDR_REG_SEL  8'h0C
`define CBFLE_ADDR_REG_DATA 8'h10
`define CBFLE_ADDR_STATUS   8'h14
// ----------------------------------------
// processor flag register bit positions
// ----------------------------------------
`define CBFLE_FLAG_C 3'h0
`define CBFLE_FLAG_Z 3'h1
`define CBFLE_FLAG_N 3'h2
`define CBFLE_FLAG_V 3'h3
`define CBFLE_FLAG_S 3'h4
`define CBFLE_FLAG_H 3'h5
`define CBFLE_FLAG_T 3'h6
`define CBFLE_FLAG_I 3'h7
// ----------------------------------------
// instruction word fields
// ----------------------------------------
`define CBFLE_OP_HI  23
`define CBFLE_OP_LO  18
`define CBFLE_RD_HI  17
`define CBFLE_RD_LO  13
`define CBFLE_RR_HI  12
`define CBFLE_RR_LO  8
`define CBFLE_IMM_HI 7
// ----------------------------------------
// pointer pairs (low register index)
// ----------------------------------------
`define CBFLE_PTR_X 5'h1A
`define CBFLE_PTR_Y 5'h1C
`define CBFLE_PTR_Z 5'h1E
// ----------------------------------------
// reset values
// ----------------------------------------
`define CBFLE_PC_RST    16'h0000
`define CBFLE_FLAGS_RST 8'h00
`endif

// file: logic/cbfle_pkg.sv
`include "cbfle_cfg.svh"
package cbfle_pkg;
  typedef enum logic [1:0] {S_IDLE, S_FIRST, S_SECOND} cbfle_state_type;

  typedef enum logic [5:0] {
    OP_NOP, OP_BRANCH_IRQ_ON, OP_BRANCH_IRQ_OFF, OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
    OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
    OP_ARITH_RIGHT_SHIFT, OP_NIBBLE_SWAP, OP_GENERIC_FLAG_SET, OP_GENERIC_FLAG_CLEAR,
    OP_BIT_TO_TRANSFER_FLAG, OP_TRANSFER_FLAG_TO_BIT,
    OP_CARRY_SET, OP_CARRY_CLEAR, OP_NEGATIVE_SET, OP_NEGATIVE_CLEAR, OP_ZERO_SET, OP_ZERO_CLEAR,
    OP_GLOBAL_IRQ_ON, OP_GLOBAL_IRQ_OFF, OP_SIGN_SET, OP_SIGN_CLEAR, OP_OVERFLOW_SET,
    OP_OVERFLOW_CLEAR, OP_TRANSFER_FLAG_SET, OP_TRANSFER_FLAG_CLEAR, OP_HALF_CARRY_SET,
    OP_HALF_CARRY_CLEAR, OP_REGISTER_COPY, OP_REGISTER_PAIR_COPY, OP_IMMEDIATE_LOAD,
    OP_INDIRECT_LOAD, OP_INDIRECT_LOAD_INC, OP_INDIRECT_LOAD_DEC, OP_DISPLACEMENT_LOAD
  } cbfle_op_type;

  // {valid, value, index} of a dedicated flag set or clear
  function automatic logic [4:0] cbfle_flag_code(input cbfle_op_type op);
    case (op)
      OP_CARRY_SET:           return {2'b11, `CBFLE_FLAG_C};
      OP_CARRY_CLEAR:         return {2'b10, `CBFLE_FLAG_C};
      OP_NEGATIVE_SET:        return {2'b11, `CBFLE_FLAG_N};
      OP_NEGATIVE_CLEAR:      return {2'b10, `CBFLE_FLAG_N};
      OP_ZERO_SET:            return {2'b11, `CBFLE_FLAG_Z};
      OP_ZERO_CLEAR:          return {2'b10, `CBFLE_FLAG_Z};
      OP_GLOBAL_IRQ_ON:       return {2'b11, `CBFLE_FLAG_I};
      OP_GLOBAL_IRQ_OFF:      return {2'b10, `CBFLE_FLAG_I};
      OP_SIGN_SET:            return {2'b11, `CBFLE_FLAG_S};
      OP_SIGN_CLEAR:          return {2'b10, `CBFLE_FLAG_S};
      OP_OVERFLOW_SET:        return {2'b11, `CBFLE_FLAG_V};
      OP_OVERFLOW_CLEAR:      return {2'b10, `CBFLE_FLAG_V};
      OP_TRANSFER_FLAG_SET:   return {2'b11, `CBFLE_FLAG_T};
      OP_TRANSFER_FLAG_CLEAR: return {2'b10, `CBFLE_FLAG_T};
      OP_HALF_CARRY_SET:      return {2'b11, `CBFLE_FLAG_H};
      OP_HALF_CARRY_CLEAR:    return {2'b10, `CBFLE_FLAG_H};
      default:                return 5'h00;
    endcase
  endfunction : cbfle_flag_code
endpackage : cbfle_pkg

// file: logic/cbfle_alu_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cbfle_alu_if;
  import cbfle_pkg::*;
  cbfle_op_type op;
  logic [7:0]   opa;
  logic [2:0]   bitsel;
  logic [7:0]   flags_in;
  logic [7:0]   res;
  logic [7:0]   flags_out;
  modport core (output op, opa, bitsel, flags_in, input res, flags_out);
  modport unit (input op, opa, bitsel, flags_in, output res, flags_out);
endinterface : cbfle_alu_if
`default_nettype wire

// file: logic/cbfle_shift_unit.sv
`timescale 1ns/1ns
`default_nettype none
`include "cbfle_cfg.svh"
module cbfle_shift_unit
  import cbfle_pkg::*;
(
  // operands and results
  cbfle_alu_if.unit a
);
  logic [4:0] fcode;
  logic       c_new;
  logic       upd;

  always_comb begin
    a.res       = a.opa;
    a.flags_out = a.flags_in;
    fcode       = cbfle_flag_code(a.op);
    c_new       = a.flags_in[`CBFLE_FLAG_C];
    upd         = 1'b0;
    case (a.op)
      OP_LOGICAL_LEFT_SHIFT: begin
        a.res = {a.opa[6:0], 1'b0};
        c_new = a.opa[7];
        upd   = 1'b1;
      end
      OP_LOGICAL_RIGHT_SHIFT: begin
        a.res = {1'b0, a.opa[7:1]};
        c_new = a.opa[0];
        upd   = 1'b1;
      end
      OP_ROTATE_LEFT_CARRY: begin
        a.res = {a.opa[6:0], a.flags_in[`CBFLE_FLAG_C]};
        c_new = a.opa[7];
        upd   = 1'b1;
      end
      OP_ROTATE_RIGHT_CARRY: begin
        a.res = {a.flags_in[`CBFLE_FLAG_C], a.opa[7:1]};
        c_new = a.opa[0];
        upd   = 1'b1;
      end
      OP_ARITH_RIGHT_SHIFT: begin
        a.res = {a.opa[7], a.opa[7:1]};
        c_new = a.opa[0];
        upd   = 1'b1;
      end
      OP_NIBBLE_SWAP: begin
        a.res = {a.opa[3:0], a.opa[7:4]};
      end
      OP_GENERIC_FLAG_SET: begin
        a.flags_out[a.bitsel] = 1'b1;
      end
      OP_GENERIC_FLAG_CLEAR: begin
        a.flags_out[a.bitsel] = 1'b0;
      end
      OP_BIT_TO_TRANSFER_FLAG: begin
        a.flags_out[`CBFLE_FLAG_T] = a.opa[a.bitsel];
      end
      OP_TRANSFER_FLAG_TO_BIT: begin
        a.res[a.bitsel] = a.flags_in[`CBFLE_FLAG_T];
      end
      default: begin
        if (fcode[4]) begin
          a.flags_out[fcode[2:0]] = fcode[3];
        end
      end
    endcase
    // sign flag is left alone: only the four listed flags move
    if (upd) begin
      a.flags_out[`CBFLE_FLAG_C] = c_new;
      a.flags_out[`CBFLE_FLAG_Z] = (a.res == 8'h00);
      a.flags_out[`CBFLE_FLAG_N] = a.res[7];
      a.flags_out[`CBFLE_FLAG_V] = a.res[7] ^ c_new;
    end
  end
endmodule : cbfle_shift_unit
`default_nettype wire

// file: logic/cbfle_core.sv
//
// Functional notes
// - branch_irq_on jumps to PC+k+1 in two cycles if I set, else one cycle.
// - branch_irq_off jumps to PC+k+1 in two cycles if I clear, else one cycle.
// - io_bit_set_op sets one I/O register bit, flags untouched, two cycles.
// - io_bit_clear_op clears one I/O register bit, flags untouched, two cycles.
// - left shift inserts zero at bit 0, updates Z C N V, one cycle.
// - right shift inserts zero at bit 7, updates Z C N V, one cycle.
// - rotate left: old carry into bit 0, bit 7 into carry, one cycle.
// - rotate right: old carry into bit 7, bit 0 into carry, one cycle.
// - arithmetic right shift keeps sign bit, updates Z C N V.
// - nibble swap exchanges halves in one cycle, flags untouched.
// - bit store copies a register bit into T in one cycle.
// - bit load copies T into a register bit in one cycle.
// - dedicated and generic set ops force one flag to one in one cycle.
// - dedicated and generic clear ops force one flag to zero in one cycle.
// - post-increment load reads at pointer then adds one, two cycles.
// - pre-decrement load subtracts one then reads, two cycles.
// - displacement load reads Y or Z plus q, pointer kept, two cycles.
`timescale 1ns/1ns
`default_nettype none
`include "cbfle_cfg.svh"
module cbfle_core
  import cbfle_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output var  logic [31:0] o_prdata,
  output var  logic        o_pready,
  output var  logic        o_pslverr,
  // data space read port
  output var  logic [15:0] o_dmem_addr,
  output var  logic        o_dmem_rd,
  input  wire logic [7:0]  i_dmem_rdata,
  // i/o register port
  output var  logic [4:0]  o_io_addr,
  output var  logic        o_io_rd,
  input  wire logic [7:0]  i_io_rdata,
  output var  logic        o_io_we,
  output var  logic [7:0]  o_io_wdata,
  // core status
  output var  logic        o_busy,
  output var  logic        o_irq_enable
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  cbfle_state_type state,    next_state;
  logic [23:0]     ir,       next_ir;
  logic [15:0]     pc,       next_pc;
  logic [7:0]      flags,    next_flags;
  logic [4:0]      rsel,     next_rsel;
  logic [1:0]      last_cyc, next_last_cyc;
  logic [31:0]     next_prdata;
  logic            next_pready;
  logic            next_pslverr;
  logic [15:0]     next_dmem_addr;
  logic            next_dmem_rd;
  logic [4:0]      next_io_addr;
  logic            next_io_rd;
  logic            next_io_we;
  logic [7:0]      next_io_wdata;
  logic [7:0]      rf [32];
  logic            wa_en,  wb_en;
  logic [4:0]      wa_idx, wb_idx;
  logic [7:0]      wa_data, wb_data;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  cbfle_op_type op;
  logic [4:0]   rd, rr, pidx;
  logic [7:0]   imm, opa, bit_mask;
  logic [1:0]   ptr_sel;
  logic [15:0]  ptr, br_target;
  logic         acc, taken;

  // pointer pair selection is needed for the read and the write-back
  function automatic logic [4:0] ptr_index(input logic [1:0] sel);
    case (sel)
      2'h0:    return `CBFLE_PTR_X;
      2'h1:    return `CBFLE_PTR_Y;
      default: return `CBFLE_PTR_Z;
    endcase
  endfunction : ptr_index

  assign op        = cbfle_op_type'(ir[`CBFLE_OP_HI:`CBFLE_OP_LO]);
  assign rd        = ir[`CBFLE_RD_HI:`CBFLE_RD_LO];
  assign rr        = ir[`CBFLE_RR_HI:`CBFLE_RR_LO];
  assign imm       = ir[`CBFLE_IMM_HI:0];
  assign opa       = rf[rd];
  assign bit_mask  = 8'h01 << imm[2:0];
  assign ptr_sel   = (op == OP_DISPLACEMENT_LOAD) ? {rr[0], ~rr[0]} : rr[1:0];
  assign pidx      = ptr_index(ptr_sel);
  assign ptr       = {rf[pidx + 5'h01], rf[pidx]};
  assign br_target = pc + {{8{imm[7]}}, imm} + 16'h0001;
  assign taken     = (op == OP_BRANCH_IRQ_ON)  ?  flags[`CBFLE_FLAG_I] :
                     (op == OP_BRANCH_IRQ_OFF) ? ~flags[`CBFLE_FLAG_I] :
                     1'b0;
  assign acc       = i_psel & i_penable & o_pready;

  // ----------------------------------------
  // shift and flag unit
  // ----------------------------------------
  cbfle_alu_if alu ();
  assign alu.op       = op;
  assign alu.opa      = opa;
  assign alu.bitsel   = imm[2:0];
  assign alu.flags_in = flags;
  cbfle_shift_unit u_shift (.a(alu));

  // ----------------------------------------
  // next values
  // ----------------------------------------
  always_comb begin
    next_state     = state;
    next_ir        = ir;
    next_pc        = pc;
    next_flags     = flags;
    next_rsel      = rsel;
    next_last_cyc  = last_cyc;
    next_dmem_addr = o_dmem_addr;
    next_dmem_rd   = 1'b0;
    next_io_addr   = o_io_addr;
    next_io_rd     = 1'b0;
    next_io_we     = 1'b0;
    next_io_wdata  = o_io_wdata;
    wa_en          = 1'b0;
    wa_idx         = rd;
    wa_data        = alu.res;
    wb_en          = 1'b0;
    wb_idx         = pidx + 5'h01;
    wb_data        = 8'h00;
    // one wait state lets read data come from a flop
    next_pready    = i_psel & i_penable & ~o_pready;
    next_pslverr   = 1'b0;
    next_prdata    = o_prdata;
    if (i_psel & i_penable & ~o_pready) begin
      next_prdata = 32'h0000_0000;
      case (i_paddr)
        `CBFLE_ADDR_INSTR:    next_prdata = {8'h00, ir};
        `CBFLE_ADDR_FLAGS:    next_prdata = {24'h00_0000, flags};
        `CBFLE_ADDR_PC:       next_prdata = {16'h0000, pc};
        `CBFLE_ADDR_REG_SEL:  next_prdata = {27'h000_0000, rsel};
        `CBFLE_ADDR_REG_DATA: next_prdata = {24'h00_0000, rf[rsel]};
        `CBFLE_ADDR_STATUS:   next_prdata = {22'h00_0000, last_cyc, 7'h00, o_busy};
        default:              next_pslverr = 1'b1;
      endcase
    end
    case (state)
      S_IDLE: begin
        // writes are ignored while an instruction is in flight
        if (acc & i_pwrite) begin
          case (i_paddr)
            `CBFLE_ADDR_INSTR: begin
              next_ir    = i_pwdata[23:0];
              next_state = S_FIRST;
            end
            `CBFLE_ADDR_FLAGS:    next_flags = i_pwdata[7:0];
            `CBFLE_ADDR_PC:       next_pc    = i_pwdata[15:0];
            `CBFLE_ADDR_REG_SEL:  next_rsel  = i_pwdata[4:0];
            `CBFLE_ADDR_REG_DATA: begin
              wa_en   = 1'b1;
              wa_idx  = rsel;
              wa_data = i_pwdata[7:0];
            end
            default: ;
          endcase
        end
      end
      S_FIRST: begin
        next_state    = S_IDLE;
        next_pc       = pc + 16'h0001;
        next_last_cyc = 2'h1;
        case (op)
          OP_BRANCH_IRQ_ON, OP_BRANCH_IRQ_OFF: begin
            if (taken) begin
              next_state = S_SECOND;
              next_pc    = pc;
            end
          end
          OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
            next_state   = S_SECOND;
            next_pc      = pc;
            next_io_addr = rr;
            next_io_rd   = 1'b1;
          end
          OP_INDIRECT_LOAD, OP_INDIRECT_LOAD_INC, OP_INDIRECT_LOAD_DEC, OP_DISPLACEMENT_LOAD: begin
            next_state     = S_SECOND;
            next_pc        = pc;
            next_dmem_rd   = 1'b1;
            next_dmem_addr = ptr;
            wa_idx         = pidx;
            if (op == OP_INDIRECT_LOAD_INC) begin
              {wb_data, wa_data} = ptr + 16'h0001;
              wa_en = 1'b1;
              wb_en = 1'b1;
            end else if (op == OP_INDIRECT_LOAD_DEC) begin
              next_dmem_addr     = ptr - 16'h0001;
              {wb_data, wa_data} = ptr - 16'h0001;
              wa_en = 1'b1;
              wb_en = 1'b1;
            end else if (op == OP_DISPLACEMENT_LOAD) begin
              next_dmem_addr = ptr + {10'h000, imm[5:0]};
            end
          end
          OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
          OP_ARITH_RIGHT_SHIFT, OP_NIBBLE_SWAP, OP_TRANSFER_FLAG_TO_BIT: begin
            wa_en      = 1'b1;
            next_flags = alu.flags_out;
          end
          OP_REGISTER_COPY: begin
            wa_en   = 1'b1;
            wa_data = rf[rr];
          end
          OP_IMMEDIATE_LOAD: begin
            wa_en   = 1'b1;
            wa_data = imm;
          end
          OP_REGISTER_PAIR_COPY: begin
            wa_en   = 1'b1;
            wb_en   = 1'b1;
            wa_idx  = {rd[4:1], 1'b0};
            wb_idx  = {rd[4:1], 1'b1};
            wa_data = rf[{rr[4:1], 1'b0}];
            wb_data = rf[{rr[4:1], 1'b1}];
          end
          default: next_flags = alu.flags_out;
        endcase
      end
      S_SECOND: begin
        next_state    = S_IDLE;
        next_pc       = taken ? br_target : pc + 16'h0001;
        next_last_cyc = 2'h2;
        // the i/o write strobe rises on the same edge that returns the state to S_IDLE
        if (op == OP_IO_BIT_SET) begin
          next_io_we    = 1'b1;
          next_io_wdata = i_io_rdata | bit_mask;
        end else if (op == OP_IO_BIT_CLEAR) begin
          next_io_we    = 1'b1;
          next_io_wdata = i_io_rdata & ~bit_mask;
        end else if (!taken) begin
          wa_en   = 1'b1;
          wa_data = i_dmem_rdata;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state       <= S_IDLE;
      ir          <= 24'h00_0000;
      pc          <= `CBFLE_PC_RST;
      flags       <= `CBFLE_FLAGS_RST;
      rsel        <= 5'h00;
      last_cyc    <= 2'h0;
      o_prdata    <= 32'h0000_0000;
      o_pready    <= 1'b0;
      o_pslverr   <= 1'b0;
      o_dmem_addr <= 16'h0000;
      o_dmem_rd   <= 1'b0;
      o_io_addr   <= 5'h00;
      o_io_rd     <= 1'b0;
      o_io_we     <= 1'b0;
      o_io_wdata  <= 8'h00;
      o_busy      <= 1'b0;
    end else begin
      state       <= next_state;
      ir          <= next_ir;
      pc          <= next_pc;
      flags       <= next_flags;
      rsel        <= next_rsel;
      last_cyc    <= next_last_cyc;
      o_prdata    <= next_prdata;
      o_pready    <= next_pready;
      o_pslverr   <= next_pslverr;
      o_dmem_addr <= next_dmem_addr;
      o_dmem_rd   <= next_dmem_rd;
      o_io_addr   <= next_io_addr;
      o_io_rd     <= next_io_rd;
      o_io_we     <= next_io_we;
      o_io_wdata  <= next_io_wdata;
      o_busy      <= (next_state != S_IDLE);
    end
  end

  // working registers carry no reset: software must load them before use
  always_ff @(posedge i_clk) begin
    if (wa_en) begin
      rf[wa_idx] <= wa_data;
    end
    if (wb_en) begin
      rf[wb_idx] <= wb_data;
    end
  end

  assign o_irq_enable = flags[`CBFLE_FLAG_I];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  logic [4:0] fcode;
  logic       sel_bit;
  assign fcode   = cbfle_flag_code(op);
  assign sel_bit = opa[imm[2:0]];

  sequence s_second_then_idle;
    (state == S_SECOND) ##1 (state == S_IDLE);
  endsequence

  a_irq_on_taken: assert property ((state == S_FIRST && op == OP_BRANCH_IRQ_ON && flags[`CBFLE_FLAG_I])
    |=> s_second_then_idle ##0 (pc == $past(br_target, 2))) else $error("taken branch wrong");
  a_irq_on_fall: assert property ((state == S_FIRST && op == OP_BRANCH_IRQ_ON && !flags[`CBFLE_FLAG_I])
    |=> (state == S_IDLE && pc == $past(pc) + 16'h0001)) else $error("fall-through wrong");
  a_irq_off_taken: assert property ((state == S_FIRST && op == OP_BRANCH_IRQ_OFF && !flags[`CBFLE_FLAG_I])
    |=> s_second_then_idle ##0 (pc == $past(br_target, 2))) else $error("taken branch wrong");
  a_io_set_rmw: assert property ((state == S_SECOND && op == OP_IO_BIT_SET)
    |=> (o_io_we && o_io_wdata == ($past(i_io_rdata) | $past(bit_mask)))) else $error("bit set wrong");
  a_io_clear_rmw: assert property ((state == S_FIRST && op == OP_IO_BIT_CLEAR) |=> o_io_rd ##1
    (o_io_we && o_io_wdata == ($past(i_io_rdata) & ~$past(bit_mask)))) else $error("bit clear wrong");
  a_left_shift_flags: assert property ((state == S_FIRST && op == OP_LOGICAL_LEFT_SHIFT)
    |=> (flags[`CBFLE_FLAG_C] == $past(opa[7]) && state == S_IDLE)) else $error("left shift wrong");
  a_right_shift_flags: assert property ((state == S_FIRST && op == OP_LOGICAL_RIGHT_SHIFT)
    |=> (flags[`CBFLE_FLAG_C] == $past(opa[0]) && !flags[`CBFLE_FLAG_N])) else $error("right shift wrong");
  a_swap_keeps_flags: assert property ((state == S_FIRST && op == OP_NIBBLE_SWAP)
    |=> (flags == $past(flags))) else $error("swap touched flags");
  a_bit_to_t: assert property ((state == S_FIRST && op == OP_BIT_TO_TRANSFER_FLAG)
    |=> (flags[`CBFLE_FLAG_T] == $past(sel_bit))) else $error("bit store wrong");
  a_flag_force: assert property ((state == S_FIRST && fcode[4])
    |=> (flags[$past(fcode[2:0])] == $past(fcode[3]))) else $error("flag force wrong");
  a_load_post_inc: assert property ((state == S_FIRST && op == OP_INDIRECT_LOAD_INC)
    |=> (o_dmem_rd && o_dmem_addr == $past(ptr) && ptr == $past(ptr) + 16'h0001)) else $error("post-inc wrong");
  a_load_pre_dec: assert property ((state == S_FIRST && op == OP_INDIRECT_LOAD_DEC)
    |=> (o_dmem_addr == $past(ptr) - 16'h0001 && ptr == o_dmem_addr)) else $error("pre-dec wrong");
  a_load_disp: assert property ((state == S_FIRST && op == OP_DISPLACEMENT_LOAD)
    |=> (o_dmem_addr == $past(ptr) + {10'h000, imm[5:0]} && ptr == $past(ptr))) else $error("disp wrong");
endmodule : cbfle_core
`default_nettype wire

// file: bench/test_cpu_bit_flag_load_exec.sv
`timescale 1ns/1ns
`default_nettype none
`include "cbfle_cfg.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_cpu_bit_flag_load_exec;
  // ----------------------------------------
  // stimulus, memory models and design
  // ----------------------------------------
  logic        i_clk;
  logic        i_rst_b   = 1'b0;
  logic        i_psel    = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite  = 1'b0;
  logic [7:0]  i_paddr   = 8'h00;
  logic [31:0] i_pwdata  = 32'h0;
  logic [31:0] o_prdata;
  logic        o_pready, o_pslverr, o_dmem_rd, o_io_rd, o_io_we, o_busy, o_irq_enable;
  logic [15:0] o_dmem_addr;
  logic [4:0]  o_io_addr;
  logic [7:0]  o_io_wdata, i_dmem_rdata, i_io_rdata, io_seen, lo;
  logic        err;
  logic [1:0]  cy;
  logic [31:0] q;
  int          n_fail     = 0;
  int          num_checks = 0;
  int          cyc        = 0;
  int          n_rd       = 0;
  // data bytes depend on both address halves so a wrong pointer byte shows up
  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction : mem
  assign i_dmem_rdata = mem(o_dmem_addr);
  assign i_io_rdata   = {3'h2, o_io_addr};
  cbfle_core u_cbfle_core (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_dmem_addr(o_dmem_addr), .o_dmem_rd(o_dmem_rd), .i_dmem_rdata(i_dmem_rdata),
    .o_io_addr(o_io_addr), .o_io_rd(o_io_rd), .i_io_rdata(i_io_rdata), .o_io_we(o_io_we),
    .o_io_wdata(o_io_wdata), .o_busy(o_busy), .o_irq_enable(o_irq_enable));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_io_we === 1'b1) begin
      io_seen <= o_io_wdata;
    end
    if (o_dmem_rd === 1'b1 || o_io_rd === 1'b1) begin
      n_rd <= n_rd + 1;
    end
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic close_out();
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge i_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    r         = o_prdata;
    err       = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : xfer
  // a write while busy is dropped, so status is polled before returning
  task automatic ex(input logic [5:0] op, input logic [4:0] d, input logic [4:0] r, input logic [7:0] k);
    xfer(1'b1, `CBFLE_ADDR_INSTR, {8'h00, op, d, r, k}, q);
    do xfer(1'b0, `CBFLE_ADDR_STATUS, 32'h0, q); while (q[0] !== 1'b0);
    cy = q[9:8];
  endtask : ex
  task automatic setr(input logic [4:0] i, input logic [7:0] v);
    xfer(1'b1, `CBFLE_ADDR_REG_SEL, {27'h0, i}, q);
    xfer(1'b1, `CBFLE_ADDR_REG_DATA, {24'h0, v}, q);
  endtask : setr
  task automatic gr(input logic [4:0] i);
    xfer(1'b1, `CBFLE_ADDR_REG_SEL, {27'h0, i}, q);
    xfer(1'b0, `CBFLE_ADDR_REG_DATA, 32'h0, q);
  endtask : gr
  // ----------------------------------------
  // tests
  // ----------------------------------------
  logic [2:0]  pos[8] = '{0, 2, 1, 7, 4, 3, 6, 5};
  logic [5:0]  bop[4] = '{6'h01, 6'h02, 6'h02, 6'h01};
  logic [7:0]  bfl[4] = '{8'h80, 8'h80, 8'h00, 8'h00};
  logic [7:0]  bk[4]  = '{8'h05, 8'h05, 8'hFE, 8'hFE};
  logic [5:0]  sop[6] = '{6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0A};
  logic [7:0]  sin[6] = '{8'h81, 8'h01, 8'h40, 8'h02, 8'h81, 8'h3C};
  logic [7:0]  sfi[6] = '{8'h70, 8'h00, 8'h01, 8'h21, 8'h00, 8'h5A};
  logic [7:0]  srs[6] = '{8'h02, 8'h00, 8'h81, 8'h81, 8'hC0, 8'hC3};
  logic [7:0]  sfo[6] = '{8'h79, 8'h0B, 8'h0C, 8'h2C, 8'h05, 8'h5A};
  logic [15:0] lea[4] = '{16'h1234, 16'h20FF, 16'h2FFF, 16'h213F};
  logic [15:0] pe[3]  = '{16'h1234, 16'h2100, 16'h2FFF};
  logic [15:0] pst[3] = '{16'h1234, 16'h20FF, 16'h3000};
  logic        tk;
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    xfer(1'b0, 8'h18, 32'h0, q);
    `CHK("unmapped_err", 1'b1, err)
    for (int i = 0; i < 8; i++) begin
      ex(6'(15 + 2 * i), 5'h00, 5'h00, 8'h00);
      `CHK("ded_set_cyc", 2'h1, cy)
      `CHK("irq_flag", 1'(pos[i] == 3'h7), o_irq_enable)
      xfer(1'b0, `CBFLE_ADDR_FLAGS, 32'h0, q);
      `CHK("ded_set", 8'h01 << pos[i], q[7:0])
      ex(6'(16 + 2 * i), 5'h00, 5'h00, 8'h00);
      xfer(1'b0, `CBFLE_ADDR_FLAGS, 32'h0, q);
      `CHK("ded_clr", 8'h00, q[7:0])
      ex(6'h0B, 5'h00, 5'h00, 8'(i));
      xfer(1'b0, `CBFLE_ADDR_FLAGS, 32'h0, q);
      `CHK("gen_set", 8'h01 << i, q[7:0])
      ex(6'h0C, 5'h00, 5'h00, 8'(i));
      xfer(1'b0, `CBFLE_ADDR_FLAGS, 32'h0, q);
      `CHK("gen_clr", 8'h00, q[7:0])
    end
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, `CBFLE_ADDR_FLAGS, {24'h0, bfl[i]}, q);
      xfer(1'b1, `CBFLE_ADDR_PC, 32'h10, q);
      ex(bop[i], 5'h00, 5'h00, bk[i]);
      tk = (bop[i] == 6'h01) == bfl[i][7];
      xfer(1'b0, `CBFLE_ADDR_PC, 32'h0, q);
      `CHK("branch_pc", tk ? 16'h0011 + {{8{bk[i][7]}}, bk[i]} : 16'h0011, q[15:0])
      `CHK("branch_cyc", tk ? 2'h2 : 2'h1, cy)
    end
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, `CBFLE_ADDR_FLAGS, {24'h0, sfi[i]}, q);
      setr(5'h05, sin[i]);
      ex(sop[i], 5'h05, 5'h05, 8'h00);
      `CHK("shift_cyc", 2'h1, cy)
      gr(5'h05);
      `CHK("shift_res", srs[i], q[7:0])
      xfer(1'b0, `CBFLE_ADDR_FLAGS, 32'h0, q);
      `CHK("shift_flags", sfo[i], q[7:0])
    end
    xfer(1'b1, `CBFLE_ADDR_FLAGS, 32'h0, q);
    setr(5'h05, 8'h08);
    setr(5'h06, 8'h00);
    ex(6'h0D, 5'h05, 5'h05, 8'h03);
    ex(6'h0E, 5'h06, 5'h06, 8'h07);
    `CHK("bit_load_cyc", 2'h1, cy)
    gr(5'h06);
    `CHK("bit_load", 8'h80, q[7:0])
    xfer(1'b0, `CBFLE_ADDR_FLAGS, 32'h0, q);
    `CHK("bit_store", 8'h40, q[7:0])
    xfer(1'b1, `CBFLE_ADDR_FLAGS, 32'h3F, q);
    ex(6'h21, 5'h07, 5'h00, 8'hC3);
    ex(6'h1F, 5'h08, 5'h07, 8'h00);
    ex(6'h20, 5'h0A, 5'h07, 8'h00);
    `CHK("pair_cyc", 2'h1, cy)
    gr(5'h08);
    `CHK("copy", 8'hC3, q[7:0])
    gr(5'h0A);
    lo = q[7:0];
    gr(5'h0B);
    `CHK("pair_copy", 16'hC380, {q[7:0], lo})
    xfer(1'b0, `CBFLE_ADDR_FLAGS, 32'h0, q);
    `CHK("move_flags", 8'h3F, q[7:0])
    for (int i = 0; i < 6; i++) begin
      setr(5'(26 + i), i[0] ? pst[i / 2][15:8] : pst[i / 2][7:0]);
    end
    for (int i = 0; i < 4; i++) begin
      ex(6'(34 + i), 5'h04, i == 3 ? 5'h00 : 5'(i), i == 3 ? 8'h3F : 8'h00);
      `CHK("load_cyc", 2'h2, cy)
      gr(5'h04);
      `CHK("load_data", mem(lea[i]), q[7:0])
    end
    `CHK("load_strobes", 4, n_rd)
    for (int j = 0; j < 3; j++) begin
      gr(5'(26 + 2 * j));
      lo = q[7:0];
      gr(5'(27 + 2 * j));
      `CHK("pointer", pe[j], {q[7:0], lo})
    end
    ex(6'h03, 5'h00, 5'h11, 8'h03);
    `CHK("io_set_cyc", 2'h2, cy)
    `CHK("io_set", 8'h59, io_seen)
    ex(6'h04, 5'h00, 5'h11, 8'h06);
    `CHK("io_clr_cyc", 2'h2, cy)
    `CHK("io_clr", 8'h11, io_seen)
    `CHK("io_addr", 5'h11, o_io_addr)
    `CHK("io_strobes", 6, n_rd)
    xfer(1'b1, `CBFLE_ADDR_PC, 32'h20, q);
    ex(6'h26, 5'h00, 5'h00, 8'h00);
    xfer(1'b0, `CBFLE_ADDR_PC, 32'h0, q);
    `CHK("nop_pc", 16'h0021, q[15:0])
    xfer(1'b0, `CBFLE_ADDR_FLAGS, 32'h0, q);
    `CHK("io_flags", 8'h3F, q[7:0])
    close_out();
  end
endmodule : test_cpu_bit_flag_load_exec
`default_nettype wire
